// ---- core/lfs_defs.vh ----
/*
 * Constants for the LED fault status capture block: status frame layout,
 * shift register size and reset values.
 * Assumes inclusion by bare name from the core files only.
 */
`ifndef LFS_DEFS_VH
`define LFS_DEFS_VH

`define LFS_SR_WIDTH        193
`define LFS_SR_MSB          192
`define LFS_GS_BITS         192
`define LFS_LOW_BITS        132
`define LFS_LEAK_HI_POS     132
`define LFS_RSV0_POS        140
`define LFS_SHORT_LO_POS    144
`define LFS_RSV1_POS        152
`define LFS_SHORT_HI_POS    156
`define LFS_RSV2_POS        164
`define LFS_OPEN_LO_POS     168
`define LFS_RSV3_POS        176
`define LFS_OPEN_HI_POS     180
`define LFS_RSV4_POS        188
`define LFS_RSV_VALUE       4'h0
`define LFS_FLAG_RESET      16'h0000
`define LFS_SYNC_RESET      3'h0

`endif

// ---- core/lfs_fault_status.v ----
/*
 * LED fault status capture: per-channel open, short and leakage flags,
 * grayscale latch and the serial shift register that reads them back.
 * Assumes comparators, PWM engine and control latch sit outside; their
 * signals arrive on ref_clk. Serial pins arrive asynchronously.
 */
// Functional notes
// - leakage flags of channels 8..15 go to frame bits 132..139
// - frame bits 140-143,152-155,164-167,176-179,188-191 are reserved
// - short flags of channels 0..7 go to frame bits 144..151
// - short flags of channels 8..15 go to frame bits 156..163
// - open flags of channels 0..7 go to frame bits 168..175
// - open flags of channels 8..15 go to frame bits 180..187
// - open flag set when channel on and output below open threshold
// - open flags latched at timing strobe; off channels zero unless INVISIBLE_DETECTION_MODE
// - short flag set when channel on and output above short threshold
// - short flags latched at timing strobe; off channels zero unless INVISIBLE_DETECTION_MODE
// - off channels get test current; leakage when below short threshold
// - leakage detection off when enable clear or invisible mode on
// - leakage latched at display end, blank rise, or timing-reset write
// - leakage reported zero if grayscale nonzero or detection disabled
// - grayscale write copies register, then loads status unless MSB set
// - no new status load until host shifts in a new bit
// - status frame leaves on serial output, one bit per clock rise
`timescale 1ns/100ps
`include "lfs_defs.vh"

module lfs_fault_status #(
    parameter CHANNELS = 16,
    parameter GS_WIDTH = 12
) (
    input  wire                         ref_clk,
    input  wire                         reset_n,
    input  wire                         serialClk,
    input  wire                         serialIn,
    input  wire                         latchStrobe,
    input  wire [CHANNELS-1:0]          channelOn,
    input  wire [CHANNELS-1:0]          openCmpLow,
    input  wire [CHANNELS-1:0]          shortCmpHigh,
    input  wire                         latchTimingHit,
    input  wire                         invisibleDetectionMode,
    input  wire                         leakageDetectEnable,
    input  wire                         displayEnd,
    input  wire                         blankCtrl,
    input  wire                         displayTimingResetEn,
    input  wire [`LFS_LOW_BITS-1:0]     lowStatus,
    output reg                          serialOutput,
    output wire [CHANNELS-1:0]          testCurrentEn,
    output reg  [`LFS_GS_BITS-1:0]      grayscaleLatch_r,
    output reg                          gsWritePulse_r,
    output wire [CHANNELS-1:0]          openFlag,
    output wire [CHANNELS-1:0]          shortFlag,
    output wire [CHANNELS-1:0]          leakageFlag
);

    wire [2:0]                  pinLevel;
    wire [2:0]                  pinRise;
    reg  [`LFS_SR_WIDTH-1:0]    shiftReg_r;
    reg  [`LFS_SR_WIDTH-1:0]    shiftReg_nxt;
    reg                         statusArmed_r;
    reg                         statusArmed_nxt;
    reg  [CHANNELS-1:0]         openLatch_r;
    reg  [CHANNELS-1:0]         shortLatch_r;
    reg  [CHANNELS-1:0]         leakLatch_r;
    reg                         blankPrev_r;
    wire                        leakEnabled;
    wire                        leakEvent;
    wire [CHANNELS-1:0]         gsZero;
    wire [CHANNELS-1:0]         onOrIdm;
    wire                        sclkRise;
    wire                        latRise;

    lfs_pin_sync #(
        .WIDTH  (3)
    ) uPinSync (
        .clk    (ref_clk),
        .resetN (reset_n),
        .pinIn  ({latchStrobe, serialIn, serialClk}),
        .level  (pinLevel),
        .rise   (pinRise)
    );

    assign sclkRise = pinRise[0];
    assign latRise  = pinRise[2];

    // per-channel grayscale-zero test
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c = c + 1) begin : gCh
            assign gsZero[c] =
                (grayscaleLatch_r[c*GS_WIDTH +: GS_WIDTH] == {GS_WIDTH{1'b0}});
        end
    endgenerate

    assign leakEnabled = leakageDetectEnable & ~invisibleDetectionMode;
    assign testCurrentEn = {CHANNELS{leakEnabled}} & ~channelOn;
    assign leakEvent = displayEnd | (blankCtrl & ~blankPrev_r)
                     | (gsWritePulse_r & displayTimingResetEn);
    assign onOrIdm = channelOn | {CHANNELS{invisibleDetectionMode}};

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            openLatch_r  <= `LFS_FLAG_RESET;
            shortLatch_r <= `LFS_FLAG_RESET;
            leakLatch_r  <= `LFS_FLAG_RESET;
            blankPrev_r  <= 1'b0;
        end else begin
            blankPrev_r <= blankCtrl;
            if (latchTimingHit) begin
                openLatch_r  <= onOrIdm & openCmpLow;
                shortLatch_r <= onOrIdm & shortCmpHigh;
            end
            if (leakEvent) begin
                leakLatch_r <= {CHANNELS{leakEnabled}} & ~channelOn
                             & ~shortCmpHigh;
            end
        end
    end

    assign openFlag  = openLatch_r;
    assign shortFlag = shortLatch_r;
    assign leakageFlag = leakLatch_r & gsZero & {CHANNELS{leakEnabled}};

    always @* begin
        shiftReg_nxt    = shiftReg_r;
        statusArmed_nxt = statusArmed_r;
        if (sclkRise) begin
            // shift one bit per serial clock rise
            shiftReg_nxt    = {shiftReg_r[`LFS_SR_MSB-1:0], pinLevel[1]};
            statusArmed_nxt = 1'b1;
        end else if (latRise && !shiftReg_r[`LFS_SR_MSB] && statusArmed_r) begin
            shiftReg_nxt[`LFS_LOW_BITS-1:0] = lowStatus;
            shiftReg_nxt[`LFS_LEAK_HI_POS +: 8] = leakageFlag[15:8];
            shiftReg_nxt[`LFS_RSV0_POS +: 4] = `LFS_RSV_VALUE;
            shiftReg_nxt[`LFS_RSV1_POS +: 4] = `LFS_RSV_VALUE;
            shiftReg_nxt[`LFS_RSV2_POS +: 4] = `LFS_RSV_VALUE;
            shiftReg_nxt[`LFS_RSV3_POS +: 4] = `LFS_RSV_VALUE;
            shiftReg_nxt[`LFS_RSV4_POS +: 4] = `LFS_RSV_VALUE;
            shiftReg_nxt[`LFS_SHORT_LO_POS +: 8] = shortFlag[7:0];
            shiftReg_nxt[`LFS_SHORT_HI_POS +: 8] = shortFlag[15:8];
            shiftReg_nxt[`LFS_OPEN_LO_POS +: 8] = openFlag[7:0];
            shiftReg_nxt[`LFS_OPEN_HI_POS +: 8] = openFlag[15:8];
            statusArmed_nxt = 1'b0;
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shiftReg_r       <= {`LFS_SR_WIDTH{1'b0}};
            statusArmed_r    <= 1'b1;
            grayscaleLatch_r <= {`LFS_GS_BITS{1'b0}};
            gsWritePulse_r   <= 1'b0;
            serialOutput     <= 1'b0;
        end else begin
            shiftReg_r     <= shiftReg_nxt;
            statusArmed_r  <= statusArmed_nxt;
            gsWritePulse_r <= 1'b0;
            // grayscale copy on latch rise with MSB clear and no serial clock rise
            if (latRise && !sclkRise && !shiftReg_r[`LFS_SR_MSB]) begin
                grayscaleLatch_r <= shiftReg_r[`LFS_GS_BITS-1:0];
                gsWritePulse_r   <= 1'b1;
            end
            serialOutput <= shiftReg_nxt[`LFS_SR_MSB];
        end
    end

endmodule // lfs_fault_status

// ---- core/lfs_pin_sync.v ----
/*
 * Three-stage pin synchroniser with a filtered level and a rise pulse,
 * one copy per bit.
 * Assumes pins are asynchronous to clk; a change counts once stages two
 * and three agree.
 */
`timescale 1ns/100ps
`include "lfs_defs.vh"

module lfs_pin_sync #(
    parameter WIDTH = 3
) (
    input  wire             clk,
    input  wire             resetN,
    input  wire [WIDTH-1:0] pinIn,
    output wire [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            reg [2:0] stage_r;
            reg       stable_r;
            reg       rise_r;
            always @(posedge clk or negedge resetN) begin
                if (!resetN) begin
                    stage_r  <= `LFS_SYNC_RESET;
                    stable_r <= 1'b0;
                    rise_r   <= 1'b0;
                end else begin
                    stage_r <= {stage_r[1:0], pinIn[i]};
                    rise_r  <= 1'b0;
                    if (stage_r[1] == stage_r[2]) begin
                        stable_r <= stage_r[2];
                        rise_r   <= stage_r[2] & ~stable_r;
                    end
                end
            end
            assign level[i] = stable_r;
            assign rise[i]  = rise_r;
        end
    endgenerate

endmodule // lfs_pin_sync

// ---- test/led_fault_status_capture_bench.sv ----
/* Self-checking bench for lfs_fault_status with a host model.
   Assumes the bound checker and a 100 MHz ref_clk. */
`timescale 1ns/100ps
module led_fault_status_capture_bench;
    logic ref_clk, reset_n, latchTimingHit, invisibleDetectionMode;
    logic leakageDetectEnable, displayEnd, blankCtrl, dtrEn, d;
    logic [15:0] channelOn, openCmpLow, shortCmpHigh;
    logic [131:0] lowStatus;
    logic [192:0] frame;
    wire serialClk, serialIn, latchStrobe, serialOutput, gsWritePulse_r;
    wire [15:0] testCurrentEn, openFlag, shortFlag, leakageFlag;
    wire [191:0] gsLatch;
    int failures = 0, checks_done = 0, pulses = 0;
    lfs_fault_status uut (.ref_clk, .reset_n, .serialClk, .serialIn,
        .latchStrobe, .channelOn, .openCmpLow, .shortCmpHigh, .latchTimingHit,
        .invisibleDetectionMode, .leakageDetectEnable, .displayEnd, .blankCtrl,
        .displayTimingResetEn(dtrEn), .lowStatus, .serialOutput, .testCurrentEn,
        .grayscaleLatch_r(gsLatch), .gsWritePulse_r, .openFlag, .shortFlag,
        .leakageFlag);
    lfs_host_model host (.ref_clk, .serialOutput, .serialClk, .serialIn,
        .latchStrobe);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (gsWritePulse_r === 1'b1) pulses <= pulses + 1;
    task check(string what, logic [192:0] seen, logic [192:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task report_and_stop;
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task pulse_hit(logic mode);
        @(posedge ref_clk) begin
            invisibleDetectionMode <= mode;
            latchTimingHit <= 1'b1;
        end
        @(posedge ref_clk) latchTimingHit <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task test_flags;
        pulse_hit(1'b0);
        check("open", openFlag, 16'h00A7);
        check("short", shortFlag, 16'h0058);
        pulse_hit(1'b1);
        check("open idm", openFlag, 16'h31A7);
        check("short idm", shortFlag, 16'h4C58);
        check("tce idm", testCurrentEn, 16'h0000);
        @(posedge ref_clk) invisibleDetectionMode <= 1'b0;
    endtask
    task test_leak;
        @(posedge ref_clk) begin
            channelOn <= 16'h0000;
            shortCmpHigh <= 16'h0F0F;
            displayEnd <= 1'b1;
        end
        @(posedge ref_clk) displayEnd <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("tce", testCurrentEn, 16'hFFFF);
        check("leak end", leakageFlag, 16'hF0F0);
        @(posedge ref_clk) begin
            shortCmpHigh <= 16'hE4E4;
            blankCtrl <= 1'b1;
        end
        repeat (3) @(posedge ref_clk);
        check("leak blank", leakageFlag, 16'h1B1B);
    endtask
    // nonzero level on channel 8 masks its leakage; write latches leakage
    task test_gs;
        @(posedge ref_clk) begin
            shortCmpHigh <= 16'h0000;
            dtrEn <= 1'b1;
        end
        for (int i = 0; i < 193; i++) host.shift(i == 96, d);
        host.latch;
        check("gs write 2", pulses, 2);
        check("gs latch 2", gsLatch, 193'h1 << 96);
        check("leak dtr", leakageFlag, 16'hFEFF);
        @(posedge ref_clk) dtrEn <= 1'b0;
    endtask
    task test_frame;
        for (int i = 0; i < 193; i++) host.shift(1'b0, d);
        host.latch;
        check("gs write", pulses, 1);
        check("gs latch", gsLatch, 192'h0);
        for (int i = 0; i < 193; i++) host.shift(i == 0, frame[192-i]);
        check("frame", frame, {5'h00, 8'h31, 4'h0, 8'hA7, 4'h0, 8'h4C, 4'h0,
            8'h58, 4'h0, 8'h1B, lowStatus});
        host.latch;
        check("msb refuse", pulses, 1);
        test_gs;
        @(posedge ref_clk) leakageDetectEnable <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("leak off", leakageFlag, 16'h0000);
    endtask
    initial begin
        reset_n = 1'b0;
        {latchTimingHit, invisibleDetectionMode, displayEnd, blankCtrl} = 4'h0;
        leakageDetectEnable = 1'b1;
        dtrEn = 1'b0;
        channelOn = 16'h00FF;
        openCmpLow = 16'h31A7;
        shortCmpHigh = 16'h4C58;
        lowStatus = {33{4'hC}};
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("reset out", {serialOutput, openFlag}, 17'h0);
        test_flags;
        test_leak;
        test_frame;
        report_and_stop;
    end
    initial begin
        #200000;
        failures++;
        report_and_stop;
    end
endmodule // led_fault_status_capture_bench

// ---- test/lfs_fault_status_chk.sv ----
/* Port checker for the fault status core.
   Assumes binding into every lfs_fault_status instance. */
`timescale 1ns/100ps
module lfs_fault_status_chk #(
    parameter CHANNELS = 16
) (
    input wire                ref_clk,
    input wire                reset_n,
    input wire                latchTimingHit,
    input wire                invisibleDetectionMode,
    input wire                leakageDetectEnable,
    input wire [CHANNELS-1:0] channelOn,
    input wire [CHANNELS-1:0] openCmpLow,
    input wire [CHANNELS-1:0] shortCmpHigh,
    input wire [CHANNELS-1:0] openFlag,
    input wire [CHANNELS-1:0] shortFlag,
    input wire [CHANNELS-1:0] leakageFlag,
    input wire [CHANNELS-1:0] testCurrentEn,
    input wire                gsWritePulse_r,
    input wire                serialOutput
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    AST_OPEN_LATCH: assert property (latchTimingHit |=> openFlag ==
        $past((channelOn | {CHANNELS{invisibleDetectionMode}}) & openCmpLow))
        else $error("open flags captured wrongly");
    AST_SHORT_LATCH: assert property (latchTimingHit |=> shortFlag ==
        $past((channelOn | {CHANNELS{invisibleDetectionMode}}) & shortCmpHigh))
        else $error("short flags captured wrongly");
    AST_OPEN_HOLD: assert property (!latchTimingHit |=> $stable(openFlag))
        else $error("open flags moved without strobe");
    AST_SHORT_HOLD: assert property (!latchTimingHit |=> $stable(shortFlag))
        else $error("short flags moved without strobe");
    AST_TEST_CURRENT: assert property (testCurrentEn ==
        ({CHANNELS{leakageDetectEnable & ~invisibleDetectionMode}} & ~channelOn))
        else $error("test current enable wrong");
    AST_LEAK_OFF: assert property (!leakageDetectEnable ||
        invisibleDetectionMode |-> leakageFlag == '0)
        else $error("leakage reported while disabled");
    AST_GS_PULSE: assert property (gsWritePulse_r |=> !gsWritePulse_r)
        else $error("write pulse longer than one cycle");
    AST_LOAD_MSB: assert property (gsWritePulse_r |-> !serialOutput)
        else $error("loaded frame top bit not zero");
endmodule // lfs_fault_status_chk

bind lfs_fault_status lfs_fault_status_chk #(.CHANNELS(CHANNELS)) chk (
    .ref_clk, .reset_n, .latchTimingHit, .invisibleDetectionMode,
    .leakageDetectEnable, .channelOn, .openCmpLow, .shortCmpHigh, .openFlag,
    .shortFlag, .leakageFlag, .testCurrentEn, .gsWritePulse_r, .serialOutput);

// ---- test/lfs_host_model.sv ----
/* Host side of the serial chain: shifts bits, pulses the latch pin.
   Assumes ref_clk at 100 MHz; 8 cycles per half gives a 160 ns period. */
`timescale 1ns/100ps
module lfs_host_model (
    input  wire  ref_clk,
    input  wire  serialOutput,
    output logic serialClk,
    output logic serialIn,
    output logic latchStrobe
);
    initial begin
        serialClk = 1'b0;
        serialIn = 1'b0;
        latchStrobe = 1'b0;
    end
    task automatic half;
        repeat (8) @(posedge ref_clk);
    endtask
    // frame bit read before each rise
    task automatic shift(input logic din, output logic dout);
        serialIn <= din;
        half;
        dout = serialOutput;
        serialClk <= 1'b1;
        half;
        serialClk <= 1'b0;
    endtask
    task automatic latch;
        latchStrobe <= 1'b1;
        half;
        latchStrobe <= 1'b0;
        half;
    endtask
endmodule // lfs_host_model
